// File: tbp_rw_ctrl.sv
/*
 * Reader/writer side of a TypeB block protocol link: frames, sends and
 * checks blocks, keeps the block number, chains and deselects.
 * Assumes link_in is already synchronous to clk_sys and idles high.
 */
// Summary of operation
// - Bit rate selectable, 106 or 212 kbps
// - Characters: start, eight data LSB first, stop
// - SOF and EOF; data field capped 256 bytes
// - Never send CID or NAD bytes
// - Block is PCB, INF, two CRC_B bytes
// - I, R and S blocks decoded apart
// - Chained fragments carry 64 bytes each
// - Reader block number zero on activation
// - Matching I or R(ACK) toggles reader number; code toggles on R(ACK) only while the reader chains
// - Chained I-block is answered by R(ACK)
// - Error or timeout: send R(NAK)
// - Error while tag chains: send R(ACK)
// - R(ACK) differing: resend; matching: continue chain
// - Failed deselect: resend or give up
`timescale 1ns/10ps
`default_nettype none
module tbp_rw_ctrl #(
  parameter int FWT_CYC = tbp_pkg::FWT_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rate_212,
  input wire logic act_req,
  input wire logic desel_req,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [7:0] rsp_data,
  output logic rsp_last,
  output logic busy,
  output logic done,
  output logic err,
  output logic deselected,
  output logic link_out,
  input wire logic link_in
);
  function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                          input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ tbp_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_upd

  tbp_pkg::tbp_st_t st_r;
  tbp_pkg::tbp_kind_t kind_r;
  logic blk_r, tag_chain_r, tx_chain_r, desel_r, done_r, err_r;
  logic [1:0] retry_r;
  logic [6:0] tx_len_r;
  logic [7:0] txbuf [0:tbp_pkg::FRAG_LEN-1];
  logic [7:0] rxbuf [0:tbp_pkg::MAX_FIELD-1];

  // Bit timing shared by both directions
  wire [8:0] etu = rate_212 ? tbp_pkg::ETU212_CYC
                            : tbp_pkg::ETU106_CYC;

  // Transmit engine
  tbp_pkg::tbp_tseg_t tseg_r;
  logic [11:0] sh_r;
  logic [3:0] nb_r;
  logic [8:0] tcnt_r;
  logic [7:0] tpos_r;
  logic [15:0] tcrc_r;
  logic tx_go, tx_end;
  wire [7:0] tot = (kind_r == tbp_pkg::K_I)
      ? 8'(tx_len_r) + 8'(1 + tbp_pkg::CRC_BYTES)
      : 8'(1 + tbp_pkg::CRC_BYTES);
  // CID and NAD bits stay clear in every PCB that is built here
  wire [7:0] pcb_i = tbp_pkg::PCB_I | (tx_chain_r ? tbp_pkg::PCB_CHAIN : 8'h00)
                     | {7'h00, blk_r};
  wire [7:0] tx_pcb = (kind_r == tbp_pkg::K_I) ? pcb_i
      : (kind_r == tbp_pkg::K_RACK) ? (tbp_pkg::PCB_RACK | {7'h00, blk_r})
      : (kind_r == tbp_pkg::K_RNAK) ? (tbp_pkg::PCB_RNAK | {7'h00, blk_r})
      : tbp_pkg::PCB_DESEL;
  wire [7:0] tx_byte = (tpos_r == 8'h00) ? tx_pcb
      : (tpos_r == tot - 8'h02) ? ~tcrc_r[7:0]
      : (tpos_r == tot - 8'h01) ? ~tcrc_r[15:8]
      : txbuf[6'(tpos_r - 8'h01)];
  wire tbit_end = (tseg_r != tbp_pkg::TS_OFF) && (tcnt_r == etu - 9'h001);
  wire tmore = (tpos_r != tot);

  assign link_out = (tseg_r == tbp_pkg::TS_OFF) ? 1'b1 : sh_r[0];
  assign tx_end = tbit_end && (nb_r == 4'h1) && (tseg_r == tbp_pkg::TS_EOF);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tseg_r <= tbp_pkg::TS_OFF;
      sh_r <= '0;
      nb_r <= '0;
      tcnt_r <= '0;
      tpos_r <= '0;
      tcrc_r <= tbp_pkg::CRC_INIT;
    end else if (tx_go) begin
      tseg_r <= tbp_pkg::TS_SOF;
      sh_r <= tbp_pkg::SH_SOF;
      nb_r <= tbp_pkg::NB_SOF;
      tcnt_r <= '0;
      tpos_r <= '0;
      tcrc_r <= tbp_pkg::CRC_INIT;
    end else if (tbit_end) begin
      tcnt_r <= '0;
      if (nb_r != 4'h1) begin
        sh_r <= sh_r >> 1;
        nb_r <= nb_r - 4'h1;
      end else if (tseg_r != tbp_pkg::TS_EOF && tmore) begin
        tseg_r <= tbp_pkg::TS_DATA;
        sh_r <= {2'b00, 1'b1, tx_byte, 1'b0};
        nb_r <= tbp_pkg::NB_CHAR;
        tpos_r <= tpos_r + 8'h01;
        // CRC frozen once its own bytes start going out
        if (tpos_r < tot - 8'h02) begin
          tcrc_r <= crc_upd(tcrc_r, tx_byte);
        end
      end else if (tseg_r != tbp_pkg::TS_EOF) begin
        tseg_r <= tbp_pkg::TS_EOF;
        sh_r <= tbp_pkg::SH_EOF;
        nb_r <= tbp_pkg::NB_CHAR;
      end else begin
        tseg_r <= tbp_pkg::TS_OFF;
      end
    end else if (tseg_r != tbp_pkg::TS_OFF) begin
      tcnt_r <= tcnt_r + 9'h001;
    end
  end

  // Receive engine: ten samples per character at mid-bit
  tbp_pkg::tbp_rseg_t rseg_r;
  logic [9:0] rsh_r;
  logic [3:0] rnb_r;
  logic [8:0] rcnt_r;
  logic in_frame_r, ovf_r, rx_end_r;
  logic [8:0] rx_len_r;
  logic [15:0] rcrc_r;
  wire rx_en = (st_r == tbp_pkg::ST_RX);
  wire rsamp = (rseg_r == tbp_pkg::RS_BITS) && (rcnt_r == 9'h000);
  wire [9:0] rchar = {link_in, rsh_r[9:1]};
  wire rchar_done = rsamp && (rnb_r == 4'h1);
  // Ten low bits is a delimiter: first one opens, next one closes
  wire rdelim = (rchar == 10'h000);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rseg_r <= tbp_pkg::RS_HIGH;
      rsh_r <= '0;
      rnb_r <= '0;
      rcnt_r <= '0;
    end else if (!rx_en) begin
      rseg_r <= tbp_pkg::RS_HIGH;
    end else begin
      case (rseg_r)
        tbp_pkg::RS_HIGH: begin
          if (link_in) begin
            rseg_r <= tbp_pkg::RS_LOW;
          end
        end
        tbp_pkg::RS_LOW: begin
          if (!link_in) begin
            rseg_r <= tbp_pkg::RS_BITS;
            rcnt_r <= 9'(etu >> 1);
            rnb_r <= tbp_pkg::NB_CHAR;
          end
        end
        tbp_pkg::RS_BITS: begin
          rcnt_r <= rsamp ? etu - 9'h001 : rcnt_r - 9'h001;
          if (rsamp) begin
            rsh_r <= rchar;
            rnb_r <= rnb_r - 4'h1;
            if (rnb_r == 4'h1) begin
              rseg_r <= tbp_pkg::RS_HIGH;
            end
          end
        end
        default: rseg_r <= tbp_pkg::RS_HIGH;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_frame_r <= 1'b0;
      ovf_r <= 1'b0;
      rx_end_r <= 1'b0;
      rx_len_r <= '0;
      rcrc_r <= tbp_pkg::CRC_INIT;
    end else begin
      // Held until the next frame goes out, so evaluation still sees it
      if (tx_go) begin
        rx_end_r <= 1'b0;
      end
      if (!rx_en) begin
        in_frame_r <= 1'b0;
      end else if (rchar_done && rdelim) begin
        in_frame_r <= !in_frame_r;
        rx_end_r <= in_frame_r;
        if (!in_frame_r) begin
          rx_len_r <= '0;
          ovf_r <= 1'b0;
          rcrc_r <= tbp_pkg::CRC_INIT;
        end
      end else if (rchar_done && in_frame_r && rchar[9]) begin
        if (rx_len_r == 9'(tbp_pkg::MAX_FIELD)) begin
          ovf_r <= 1'b1;
        end else begin
          rx_len_r <= rx_len_r + 9'h001;
          rcrc_r <= crc_upd(rcrc_r, rchar[8:1]);
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rx_en && rchar_done && in_frame_r && rchar[9] && !rx_len_r[8]) begin
      rxbuf[rx_len_r[7:0]] <= rchar[8:1];
    end
  end

  // Block decode of the received frame
  wire [7:0] pcb = rxbuf[0];
  wire crc_ok = (rcrc_r == tbp_pkg::CRC_RESID)
                && (rx_len_r > 9'(tbp_pkg::CRC_BYTES));
  wire legal = crc_ok && !ovf_r && ((pcb & tbp_pkg::MSK_OPT) == 8'h00);
  wire is_i = ((pcb & tbp_pkg::MSK_I) == tbp_pkg::PCB_I);
  wire is_r = ((pcb & tbp_pkg::MSK_R) == tbp_pkg::VAL_R);
  // Any S-block other than a deselect (such as WTX) counts as illegal
  wire is_desel = ((pcb & tbp_pkg::MSK_S) == tbp_pkg::PCB_DESEL);
  wire num_eq = (pcb[tbp_pkg::BIT_BLK] == blk_r);
  wire rx_chain = pcb[tbp_pkg::BIT_CHAIN];
  wire [8:0] inf_end = rx_len_r - 9'(tbp_pkg::CRC_BYTES);

  // Frame waiting timer
  logic [tbp_pkg::FWT_W-1:0] fwt_r;
  wire fwt_out = (fwt_r == tbp_pkg::FWT_W'(FWT_CYC));

  // Response path through the two-entry buffer
  logic [8:0] rd_r;
  logic [6:0] ld_r;
  wire bin_ready;
  wire drain_push = (st_r == tbp_pkg::ST_DRAIN) && (rd_r != inf_end);
  wire last_inf = (rd_r == inf_end - 9'h001);
  logic [8:0] bout;

  tbp_buf2 #(.W(9)) u_rsp_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(drain_push),
    .in_ready(bin_ready),
    .in_data({last_inf && !rx_chain, rxbuf[rd_r[7:0]]}),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(bout)
  );
  assign rsp_data = bout[7:0];
  assign rsp_last = bout[8];

  assign cmd_ready = (st_r == tbp_pkg::ST_LOAD);
  wire cmd_take = cmd_valid && cmd_ready;
  wire frag_full = (ld_r == 7'(tbp_pkg::FRAG_LEN - 1));
  assign busy = (st_r != tbp_pkg::ST_IDLE);
  assign done = done_r;
  assign err = err_r;
  assign deselected = desel_r;
  assign tx_go = (st_r == tbp_pkg::ST_TX) && (tseg_r == tbp_pkg::TS_OFF)
                 && !tx_end;

  always_ff @(posedge clk_sys) begin
    if (cmd_take) begin
      txbuf[ld_r[5:0]] <= cmd_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fwt_r <= '0;
    end else begin
      // Restarts on every character, so a cut frame also times out
      fwt_r <= (!rx_en || fwt_out || rchar_done) ? '0 : fwt_r + 1'b1;
    end
  end

  // Protocol sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= tbp_pkg::ST_IDLE;
      kind_r <= tbp_pkg::K_I;
      blk_r <= 1'b0;
      tag_chain_r <= 1'b0;
      tx_chain_r <= 1'b0;
      desel_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      retry_r <= '0;
      tx_len_r <= '0;
      ld_r <= '0;
      rd_r <= '0;
    end else begin
      done_r <= 1'b0;
      err_r <= 1'b0;
      case (st_r)
        tbp_pkg::ST_IDLE: begin
          retry_r <= '0;
          ld_r <= '0;
          if (act_req) begin
            blk_r <= 1'b0;
            tag_chain_r <= 1'b0;
            desel_r <= 1'b0;
          end else if (desel_req) begin
            kind_r <= tbp_pkg::K_DESEL;
            st_r <= tbp_pkg::ST_TX;
          end else if (cmd_valid) begin
            st_r <= tbp_pkg::ST_LOAD; // Reader always opens the exchange
          end
        end
        tbp_pkg::ST_LOAD: begin
          if (cmd_take) begin
            ld_r <= ld_r + 7'h01;
            if (cmd_last || frag_full) begin
              tx_len_r <= ld_r + 7'h01;
              tx_chain_r <= !cmd_last;
              kind_r <= tbp_pkg::K_I;
              retry_r <= '0;
              st_r <= tbp_pkg::ST_TX;
            end
          end
        end
        tbp_pkg::ST_TX: begin
          if (tx_end) begin
            st_r <= tbp_pkg::ST_RX;
          end
        end
        tbp_pkg::ST_RX: begin
          if (rx_end_r || (fwt_out && rseg_r != tbp_pkg::RS_BITS)) begin
            st_r <= tbp_pkg::ST_EVAL;
          end
        end
        tbp_pkg::ST_EVAL: begin
          rd_r <= 9'h001;
          ld_r <= '0;
          if (kind_r == tbp_pkg::K_DESEL) begin
            if (rx_end_r && legal && is_desel) begin
              desel_r <= 1'b1;
              done_r <= 1'b1;
              st_r <= tbp_pkg::ST_IDLE;
            end else if (retry_r != tbp_pkg::RETRY_MAX) begin
              retry_r <= retry_r + 2'h1;
              st_r <= tbp_pkg::ST_TX;
            end else begin
              err_r <= 1'b1;
              st_r <= tbp_pkg::ST_IDLE;
            end
          end else if (rx_end_r && legal && is_i) begin
            if (num_eq) begin
              blk_r <= !blk_r;
            end
            retry_r <= '0;
            st_r <= tbp_pkg::ST_DRAIN;
          end else if (rx_end_r && legal && is_r
                       && !pcb[tbp_pkg::BIT_NAK] && num_eq && tx_chain_r) begin
            blk_r <= !blk_r;
            st_r <= tbp_pkg::ST_LOAD;
          end else if (rx_end_r && legal && is_r
                       && !pcb[tbp_pkg::BIT_NAK] && !num_eq) begin
            kind_r <= tbp_pkg::K_I;
            st_r <= tbp_pkg::ST_TX;
          end else if (retry_r != tbp_pkg::RETRY_MAX) begin
            retry_r <= retry_r + 2'h1;
            kind_r <= tag_chain_r ? tbp_pkg::K_RACK
                                  : tbp_pkg::K_RNAK;
            st_r <= tbp_pkg::ST_TX;
          end else begin
            err_r <= 1'b1;
            st_r <= tbp_pkg::ST_IDLE;
          end
        end
        tbp_pkg::ST_DRAIN: begin
          // A full buffer stalls here; no response byte is dropped
          if (drain_push && bin_ready) begin
            rd_r <= rd_r + 9'h001;
          end else if (!drain_push) begin
            tag_chain_r <= rx_chain;
            tx_chain_r <= 1'b0;
            if (rx_chain) begin
              kind_r <= tbp_pkg::K_RACK;
              st_r <= tbp_pkg::ST_TX;
            end else begin
              done_r <= 1'b1;
              st_r <= tbp_pkg::ST_IDLE;
            end
          end
        end
        default: st_r <= tbp_pkg::ST_IDLE;
      endcase
    end
  end
endmodule : tbp_rw_ctrl
`default_nettype wire

// File: tbp_pkg.sv
/*
 * Shared constants and types for the TypeB block protocol reader controller.
 * Assumes a 50 MHz system clock; all link timing derives from it.
 */
package tbp_pkg;
  localparam int CLK_NS = 20;
  // One elementary time unit per bit at 106 kbps and 212 kbps
  localparam int ETU106_NS = 9440;
  localparam int ETU212_NS = 4720;
  localparam logic [8:0] ETU106_CYC = 9'(ETU106_NS / CLK_NS);
  localparam logic [8:0] ETU212_CYC = 9'(ETU212_NS / CLK_NS);
  // Frame waiting time, default for a waiting integer of 4
  localparam int FWT_US = 4832;
  localparam int FWT_CYC_DEF = FWT_US * 1000 / CLK_NS;
  localparam int FWT_W = 24;
  localparam int FRAG_LEN = 64;
  localparam int MAX_FIELD = 256;
  localparam logic [1:0] RETRY_MAX = 2'h3;
  // Protocol control byte values and decode masks
  localparam logic [7:0] PCB_I = 8'h02;
  localparam logic [7:0] PCB_CHAIN = 8'h10;
  localparam logic [7:0] PCB_RACK = 8'hA2;
  localparam logic [7:0] PCB_RNAK = 8'hB2;
  localparam logic [7:0] PCB_DESEL = 8'hC2;
  localparam logic [7:0] MSK_I = 8'hE2;
  localparam logic [7:0] MSK_R = 8'hE6;
  localparam logic [7:0] VAL_R = 8'hA2;
  localparam logic [7:0] MSK_S = 8'hF6;
  localparam logic [7:0] MSK_OPT = 8'h0C;
  localparam int BIT_BLK = 0;
  localparam int BIT_CHAIN = 4;
  localparam int BIT_NAK = 4;
  // CRC_B, reflected, sent inverted low byte first
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_RESID = 16'hF0B8;
  localparam int CRC_BYTES = 2;
  // Serial patterns, shifted out LSB first
  localparam logic [11:0] SH_SOF = 12'hC00;
  localparam logic [11:0] SH_EOF = 12'h000;
  localparam logic [3:0] NB_SOF = 4'hC;
  localparam logic [3:0] NB_CHAR = 4'hA;
  typedef enum logic [1:0] {K_I, K_RACK, K_RNAK, K_DESEL} tbp_kind_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_TX, ST_RX, ST_EVAL, ST_DRAIN
  } tbp_st_t;
  typedef enum logic [1:0] {TS_OFF, TS_SOF, TS_DATA, TS_EOF} tbp_tseg_t;
  typedef enum logic [1:0] {RS_LOW, RS_BITS, RS_HIGH} tbp_rseg_t;
endpackage : tbp_pkg

// File: tbp_buf2.sv
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes a single clock; in_ready is low only when both entries are full.
 */
`timescale 1ns/10ps
`default_nettype none
module tbp_buf2 #(
  parameter int W = 9
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] ent0_r, ent1_r;
  logic [1:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = ent0_r;

  // Entry 0 is always the head, so the output comes straight from a flop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 2'h0;
      ent0_r <= '0;
      ent1_r <= '0;
    end else begin
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      if (pop) begin
        ent0_r <= (cnt_r == 2'h2) ? ent1_r : in_data;
      end else if (push && cnt_r == 2'h0) begin
        ent0_r <= in_data;
      end
      if (push && (cnt_r == 2'h2 || (cnt_r == 2'h1 && !pop))) begin
        ent1_r <= in_data;
      end
    end
  end
endmodule : tbp_buf2
`default_nettype wire

// File: tbp_rw_ctrl_assertions.sv
/*
 * Port checker for tbp_rw_ctrl: handshakes, pulses and serial framing.
 * Assumes one clock and an asynchronous active-high reset; bound below.
 */
`timescale 1ns/10ps
`default_nettype none
module tbp_rw_ctrl_assertions #(
  parameter int FWT_CYC = tbp_pkg::FWT_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rate_212,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_last,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  input wire logic busy,
  input wire logic done,
  input wire logic err,
  input wire logic link_out
);
  logic [15:0] lo_cnt_r;
  logic [15:0] lo_cnt_nxt;
  logic [15:0] etu;
  // Low-run length; every low run must be whole bit times
  assign etu = rate_212 ? 16'(tbp_pkg::ETU212_CYC) : 16'(tbp_pkg::ETU106_CYC);
  assign lo_cnt_nxt = link_out ? 16'h0000 : lo_cnt_r + 16'h0001;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) lo_cnt_r <= 16'h0000;
    else lo_cnt_r <= lo_cnt_nxt;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_idle_line_high: assert property (!busy |-> link_out)
    else $error("link_out low while idle");
  a_low_run_etu: assert property (
    link_out && lo_cnt_r != 16'h0000 |->
      lo_cnt_r % etu == 16'h0000 && lo_cnt_r <= etu * 16'h000A)
    else $error("low run not whole bit times or too long");
  a_first_from_reader: assert property (
    cmd_valid && cmd_ready && cmd_last |=> !cmd_ready ##[0:8] !link_out)
    else $error("frame did not start after last command byte");
  a_done_pulse: assert property (done |-> !err ##1 !done)
    else $error("done longer than one cycle or with err");
  a_err_pulse: assert property (err |=> !err)
    else $error("err longer than one cycle");
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable(rsp_data) && $stable(rsp_last))
    else $error("stalled response word changed or dropped");
  a_ready_in_load: assert property (cmd_ready |-> busy)
    else $error("cmd_ready while idle");
  a_done_ends_busy: assert property (done |-> ##[0:2] !busy)
    else $error("busy stays after done");
endmodule : tbp_rw_ctrl_assertions
bind tbp_rw_ctrl tbp_rw_ctrl_assertions #(.FWT_CYC(FWT_CYC))
  tbp_rw_ctrl_assertions_i (.clk_sys(clk_sys), .rst(rst),
  .rate_212(rate_212), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_last(cmd_last), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
  .rsp_data(rsp_data), .rsp_last(rsp_last), .busy(busy), .done(done),
  .err(err), .link_out(link_out));
`default_nettype wire

// File: tbp_tag_model.sv
/*
 * Behavioural tag on the far side of the serial link.
 * Assumes link_out idles high and is synchronous to clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
module tbp_tag_model (
  input wire logic clk_sys,
  input wire logic rate_212,
  input wire logic act_req,
  input wire logic bad_crc,
  input wire logic link_out,
  output logic link_in,
  output logic [7:0] prot_err,
  output logic [7:0] last_pcb
);
  logic blk;
  logic spoil;
  int etu = 236;
  logic [7:0] q[$];
  logic [7:0] r[$];
  logic [7:0] last_i[$];
  function automatic logic [15:0] crc_b(input logic [7:0] d[$]);
    logic [15:0] c;
    c = tbp_pkg::CRC_INIT;
    foreach (d[i]) begin
      c = c ^ {8'h00, d[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ tbp_pkg::CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction : crc_b
  task automatic hold(input logic v, input int n);
    link_in <= v;
    repeat (n * etu) @(posedge clk_sys);
  endtask : hold
  task automatic send();
    logic [15:0] c;
    c = crc_b(r) ^ {15'h0000, spoil};
    spoil = 1'b0;
    r.push_back(c[7:0]);
    r.push_back(c[15:8]);
    hold(1'b0, 10);
    hold(1'b1, 2);
    foreach (r[i]) begin
      hold(1'b0, 1);
      for (int k = 0; k < 8; k++) hold(r[i][k], 1);
      hold(1'b1, 1);
    end
    hold(1'b0, 10);
    link_in <= 1'b1; // Released line rests at its pull-up level
  endtask : send
  // Mid-bit sampling; a zero stop bit marks the end delimiter
  task automatic recv();
    logic [7:0] b;
    q.delete();
    while (link_out !== 1'b0) @(posedge clk_sys);
    etu = rate_212 ? 236 : 472;
    repeat (11 * etu) @(posedge clk_sys);
    forever begin
      while (link_out !== 1'b0) @(posedge clk_sys);
      repeat (etu + etu / 2) @(posedge clk_sys);
      for (int k = 0; k < 8; k++) begin
        b[k] = link_out;
        repeat (etu) @(posedge clk_sys);
      end
      if (link_out !== 1'b1) break;
      q.push_back(b);
    end
    while (link_out !== 1'b1) @(posedge clk_sys);
  endtask : recv
  always @(posedge clk_sys) begin
    if (act_req === 1'b1) blk = 1'b1;
    if (bad_crc === 1'b1) spoil = 1'b1;
  end
  // Limitation: the tag never chains, so a differing R(ACK) only toggles
  initial begin
    link_in = 1'b1;
    prot_err = 8'h00;
    last_pcb = 8'h00;
    blk = 1'b1;
    spoil = 1'b0;
    forever begin
      recv();
      r.delete();
      if (q.size() < 3 || {q[$], q[$-1]} !== crc_b(q[0:$-2])) begin
        prot_err++;
      end else begin
        last_pcb = q[0];
        repeat (300) @(posedge clk_sys);
        if ((q[0] & tbp_pkg::MSK_I) == tbp_pkg::PCB_I) begin
          blk = !blk;
          if ((q[0] & tbp_pkg::MSK_OPT) != 8'h00) prot_err++;
          if (q[0][0] !== blk) prot_err++;
          if (q[0][4] && q.size() < 67) prot_err++;
          if (q[0][4]) r.push_back(tbp_pkg::PCB_RACK | blk);
          else begin
            r.push_back(tbp_pkg::PCB_I | blk);
            for (int i = 1; i < q.size() - 2; i++) r.push_back(~q[i]);
            last_i = r;
          end
        end else if ((q[0] & tbp_pkg::MSK_R) == tbp_pkg::VAL_R) begin
          if (q[0][0] == blk) r = last_i;
          else if (q[0][4]) r.push_back(tbp_pkg::PCB_RACK | blk);
          else blk = !blk;
        end else if ((q[0] & tbp_pkg::MSK_S) == tbp_pkg::PCB_DESEL) begin
          r.push_back(tbp_pkg::PCB_DESEL);
        end else prot_err++;
        if (r.size() != 0) send();
      end
    end
  end
endmodule : tbp_tag_model
`default_nettype wire

// File: tb_typeb_block_protocol_ctrl.sv
/*
 * Self-checking bench: reader controller against the behavioural tag.
 * Assumes tbp_pkg compiled first; short frame waiting time for speed.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("wrong value at %0t: %h versus %h", $time, got, exp); \
  end \
end
module tb_typeb_block_protocol_ctrl;
  typedef struct packed {
    logic desel;
    logic bad;
    logic [7:0] cmd;
    logic [7:0] rsp;
    logic [7:0] pcb;
  } tbp_row_t;
  localparam tbp_row_t ROWS [2] = '{
    '{1'b0, 1'b1, 8'h5A, 8'hA5, 8'hB2},
    '{1'b1, 1'b0, 8'h00, 8'h00, 8'hC2}};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic rate_212 = 1'b1;
  logic act_req = 1'b0;
  logic desel_req = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_last = 1'b0;
  logic rsp_ready = 1'b0;
  logic bad_crc = 1'b0;
  logic cmd_ready, rsp_valid, rsp_last, busy, done, err, deselected;
  logic link_out, link_in;
  logic [7:0] rsp_data, prot_err, last_pcb, got;
  int miscompares = 0;
  int checked = 0;
  int n_done = 0;
  int n_err = 0;
  int n;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (done === 1'b1) n_done <= n_done + 1;
    if (err === 1'b1) n_err <= n_err + 1;
  end
  tbp_rw_ctrl #(.FWT_CYC(3000)) tbp_rw_ctrl_i (.clk_sys(clk_sys),
    .rst(rst), .rate_212(rate_212), .act_req(act_req),
    .desel_req(desel_req), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_data(cmd_data), .cmd_last(cmd_last), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last),
    .busy(busy), .done(done), .err(err), .deselected(deselected),
    .link_out(link_out), .link_in(link_in));
  tbp_tag_model tbp_tag_model_i (.clk_sys(clk_sys), .rate_212(rate_212),
    .act_req(act_req), .bad_crc(bad_crc), .link_out(link_out),
    .link_in(link_in), .prot_err(prot_err), .last_pcb(last_pcb));
  task automatic tally_and_finish();
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk_idle();
    `CHK(link_out, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(cmd_ready, 1'b0)
    `CHK(rsp_valid, 1'b0)
    `CHK(deselected, 1'b0)
  endtask : chk_idle
  task automatic send_cmd(input logic [7:0] c);
    int k;
    cmd_valid <= 1'b1;
    cmd_data <= c;
    cmd_last <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (cmd_ready !== 1'b1 && k < 50);
    cmd_valid <= 1'b0;
    cmd_last <= 1'b0;
  endtask : send_cmd
  // Response is stalled a few cycles first; the buffer must hold it
  task automatic xfer(input logic [7:0] c, output logic [7:0] r);
    int k;
    send_cmd(c);
    k = 0;
    while (rsp_valid !== 1'b1 && k < 90000) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (4) @(posedge clk_sys);
    `CHK(rsp_valid, 1'b1)
    rsp_ready <= 1'b1;
    @(posedge clk_sys);
    r = rsp_data;
    `CHK(rsp_last, 1'b1)
    rsp_ready <= 1'b0;
  endtask : xfer
  task automatic wait_done(input int d0);
    int k;
    k = 0;
    while (n_done == d0 && k < 90000) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK(n_done, d0 + 1)
  endtask : wait_done
  initial begin
    repeat (99000) @(posedge clk_sys);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    chk_idle();
    rst <= 1'b0;
    @(posedge clk_sys);
    act_req <= 1'b1;
    @(posedge clk_sys);
    act_req <= 1'b0;
    foreach (ROWS[i]) begin
      n = n_done;
      bad_crc <= ROWS[i].bad;
      desel_req <= ROWS[i].desel;
      @(posedge clk_sys);
      bad_crc <= 1'b0;
      desel_req <= 1'b0;
      if (!ROWS[i].desel) begin
        xfer(ROWS[i].cmd, got);
        `CHK(got, ROWS[i].rsp)
      end
      wait_done(n);
      `CHK(last_pcb, ROWS[i].pcb)
      `CHK(deselected, ROWS[i].desel)
    end
    `CHK(n_err, 0)
    `CHK(prot_err, 8'h00)
    // Slow rate: time the start delimiter, then reset in mid-frame
    act_req <= 1'b1;
    rate_212 <= 1'b0;
    @(posedge clk_sys);
    act_req <= 1'b0;
    @(posedge clk_sys);
    `CHK(deselected, 1'b0)
    send_cmd(8'h11);
    n = 0;
    while (link_out !== 1'b0 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    n = 0;
    while (link_out === 1'b0 && n < 9000) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK(n, 10 * int'(tbp_pkg::ETU106_CYC))
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk_idle();
    tally_and_finish();
  end
endmodule : tb_typeb_block_protocol_ctrl
`default_nettype wire
